//--- core/charge_cycle_sequencer.sv
// Charge cycle sequencer: phases, safety timers, suspend and status pins.
// Assumes analog comparators deliver asynchronous levels; APB on pclk.
`timescale 1ns/100ps

module charge_cycle_sequencer
  import charge_seq_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int MIN_TICKS = MIN_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic adapter_input,
  input wire logic bus_power_input,
  input wire logic batt_above_full_rate,
  input wire logic batt_at_term,
  input wire logic batt_below_restart,
  input wire logic current_at_eoc,
  input wire logic current_at_topoff,
  input wire logic ts_too_cold,
  input wire logic ts_too_hot,
  input wire logic ts_floating,
  input wire logic charge_inhibit,
  input wire logic bus_select,
  output logic status_out_a,
  output logic status_out_a_oe,
  output logic status_out_b,
  output logic status_out_b_oe,
  output current_t charge_current,
  output logic charge_on,
  output logic cv_mode,
  output logic regulator_on,
  output logic source_adapter
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (TICK_LEN < 2 || TICK_LEN >= (1 << TICK_W)) begin : g_bad_tick
    $error("TICK_LEN must lie between 2 and 2**TICK_W - 1");
  end

  // Shorter minutes only speed up simulation; longer ones would overflow the timer.
  if (MIN_TICKS < 1 || MIN_TICKS > MIN_MS) begin : g_bad_minute
    $error("MIN_TICKS must lie between 1 and MIN_MS");
  end

  // Both filter windows must be countable in the filter counters.
  if (DGL_PIN_MS < 1 || DGL_EOC_MS > (1 << DGL_W)) begin : g_bad_filter
    $error("Deglitch windows must lie between 1 and 2**DGL_W ticks");
  end

  // A timer that cannot hold its limit would get a truncated limit and expire early.
  if (TIMER_W > 32 || CHG_LONG_H * HOUR_MS >= (1 << TIMER_W)) begin : g_bad_timer
    $error("TIMER_W must hold the longest timer and fit a 32-bit word");
  end

  // Limits are counted in ticks; a minute lasts MIN_TICKS of them.
  localparam int HOUR_TICKS = (HOUR_MS / MIN_MS) * MIN_TICKS;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_LEN - 1);
  localparam logic [TIMER_W-1:0] LIM_PREQUAL = TIMER_W'(PREQUAL_MIN * MIN_TICKS);
  localparam logic [TIMER_W-1:0] LIM_CHG_STD = TIMER_W'(CHG_STD_H * HOUR_TICKS);
  localparam logic [TIMER_W-1:0] LIM_CHG_LONG = TIMER_W'(CHG_LONG_H * HOUR_TICKS);
  localparam logic [TIMER_W-1:0] LIM_TOP_STD = TIMER_W'(TOP_STD_MIN * MIN_TICKS);
  localparam logic [TIMER_W-1:0] LIM_TOP_LONG = TIMER_W'(TOP_LONG_MIN * MIN_TICKS);

  seq_state_t r;
  seq_state_t next_r;

  // Timer class: full rate and constant voltage share the charge timer.
  function automatic logic [1:0] timer_class(input phase_t ph);
    logic [1:0] c;
    c = 2'h0;
    case (ph)
      PH_PREQUAL: c = 2'h1;
      PH_FULL, PH_CV: c = 2'h2;
      PH_TOPOFF: c = 2'h3;
      default: c = 2'h0;
    endcase
    return c;
  endfunction

  // Bit order matches the input positions of the package.
  logic [N_IN-1:0] raw_in;
  assign raw_in = {bus_select, charge_inhibit, ts_floating, ts_too_hot, ts_too_cold,
                   current_at_topoff, current_at_eoc, batt_below_restart, batt_at_term,
                   batt_above_full_rate, bus_power_input, adapter_input};

  always_comb begin
    logic have_adapter;
    logic have_power;
    logic long_timers;
    logic ts_fault;
    logic to_regulator;
    logic clear_timer;
    logic expired;
    logic [TIMER_W-1:0] limit;
    logic [DGL_W-1:0] dgl_last;
    phase_t resume;
    next_r = r;
    have_adapter = 1'b0;
    have_power = 1'b0;
    long_timers = 1'b0;
    ts_fault = 1'b0;
    to_regulator = 1'b0;
    clear_timer = 1'b0;
    expired = 1'b0;
    limit = LIM_PREQUAL;
    dgl_last = '0;
    resume = r.held;

    // ****************************************
    // Input conditioning
    // ****************************************
    // Only the second stage reads the first; a level counts once stages two and three agree.
    next_r.sync1 = raw_in;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    for (int i = 0; i < N_IN; i++) begin
      if (r.sync2[i] == r.sync3[i]) begin
        next_r.stable[i] = r.sync3[i];
      end
    end

    // One divider makes the millisecond tick; every timer and filter steps on it.
    next_r.tick = 1'b0;
    if (r.tick_cnt == TICK_LAST) begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 1'b1;
    end

    // A level must differ from the filtered value for the whole window to pass.
    for (int i = 0; i < N_DGL; i++) begin
      dgl_last = DGL_W'(DGL_MS[i] - 1);
      if (r.stable[DGL_SRC[i]] == r.dgl_val[i]) begin
        next_r.dgl_cnt[i] = '0;
      end else if (r.tick) begin
        if (r.dgl_cnt[i] == dgl_last) begin
          next_r.dgl_val[i] = r.stable[DGL_SRC[i]];
          next_r.dgl_cnt[i] = '0;
        end else begin
          next_r.dgl_cnt[i] = r.dgl_cnt[i] + 1'b1;
        end
      end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    have_adapter = r.stable[IN_ADAPTER];
    have_power = have_adapter | r.stable[IN_BUS_PWR];
    long_timers = r.config_bits[CFG_SEL_TIMER] & ~r.dgl_val[DGL_BUS_SEL];
    // A floating thermistor reads as too hot unless it selects regulator mode.
    ts_fault = r.stable[IN_TS_COLD] | r.stable[IN_TS_HOT] | r.stable[IN_TS_FLOAT];
    to_regulator = r.config_bits[CFG_REGULATOR] & r.stable[IN_TS_FLOAT]
                   & have_adapter;

    case (timer_class(r.phase))
      2'h2: limit = long_timers ? LIM_CHG_LONG : LIM_CHG_STD;
      2'h3: limit = long_timers ? LIM_TOP_LONG : LIM_TOP_STD;
      default: limit = LIM_PREQUAL;
    endcase
    expired = r.timer >= limit;

    // Priority runs: power loss, latched bad battery, regulator, power-up, pause, phase.
    if (!have_power) begin
      next_r.phase = PH_OFF;
      clear_timer = 1'b1;
    end else if (r.phase == PH_BAD) begin
      next_r.phase = PH_BAD;
    end else if (to_regulator) begin
      next_r.phase = PH_REGULATOR;
      clear_timer = 1'b1;
    end else if (r.phase == PH_REGULATOR || r.phase == PH_OFF) begin
      // A pause at power-up waits before prequalification, so status A never flashes.
      next_r.held = PH_PREQUAL;
      clear_timer = 1'b1;
      if (ts_fault || r.dgl_val[DGL_INHIBIT]) begin
        next_r.phase = ts_fault ? PH_SUSPEND : PH_INHIBIT;
      end else begin
        next_r.phase = PH_PREQUAL;
      end
    end else if (ts_fault || r.dgl_val[DGL_INHIBIT]) begin
      // The timer is left alone, so it holds its count while charging pauses.
      next_r.phase = ts_fault ? PH_SUSPEND : PH_INHIBIT;
      if (r.phase != PH_SUSPEND && r.phase != PH_INHIBIT) begin
        next_r.held = r.phase;
      end
    end else begin
      case (r.phase)
        PH_SUSPEND, PH_INHIBIT: begin
          if (r.held == PH_PREQUAL && r.stable[IN_ABOVE_FULL]) begin
            resume = PH_FULL;
          end else if (r.held == PH_FULL && r.stable[IN_AT_TERM]) begin
            resume = PH_CV;
          end
          next_r.phase = resume;
          clear_timer = timer_class(resume) != timer_class(r.held);
        end
        PH_PREQUAL: begin
          if (r.stable[IN_ABOVE_FULL]) begin
            next_r.phase = PH_FULL;
            clear_timer = 1'b1;
          end else if (expired) begin
            next_r.phase = PH_BAD;
          end
        end
        PH_FULL, PH_CV: begin
          if (expired) begin
            next_r.phase = PH_BAD;
          end else if (r.phase == PH_CV && r.dgl_val[DGL_EOC]) begin
            next_r.phase = PH_TOPOFF;
            clear_timer = 1'b1;
          end else if (r.stable[IN_AT_TERM]) begin
            next_r.phase = PH_CV;
          end
        end
        PH_TOPOFF: begin
          if (expired || r.dgl_val[DGL_TOPOFF]) begin
            next_r.phase = PH_MAINT;
          end
        end
        PH_MAINT: begin
          if (r.stable[IN_BELOW_RESTART]) begin
            next_r.phase = PH_FULL;
            clear_timer = 1'b1;
          end
        end
        default: next_r.phase = PH_OFF;
      endcase
    end

    // An expired timer stops at its limit, so the count stays readable afterwards.
    if (clear_timer) begin
      next_r.timer = '0;
    end else if (r.tick && timer_class(r.phase) != 2'h0 && !expired) begin
      next_r.timer = r.timer + 1'b1;
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Pins follow the next phase, so they change on the same edge as the phase.
    case (next_r.phase)
      PH_PREQUAL, PH_FULL, PH_CV, PH_TOPOFF: begin
        next_r.stat_a_oe = 1'b1;
        next_r.stat_b_oe = 1'b0;
      end
      PH_MAINT: begin
        next_r.stat_a_oe = 1'b0;
        next_r.stat_b_oe = 1'b1;
      end
      PH_BAD, PH_REGULATOR: begin
        next_r.stat_a_oe = 1'b1;
        next_r.stat_b_oe = 1'b1;
      end
      default: begin
        next_r.stat_a_oe = 1'b0;
        next_r.stat_b_oe = 1'b0;
      end
    endcase
    next_r.stat_a = 1'b0;
    next_r.stat_b = 1'b0;

    next_r.source_adapter = have_adapter;
    next_r.charge_on = 1'b0;
    next_r.current = CUR_OFF;
    case (next_r.phase)
      PH_PREQUAL: begin
        next_r.charge_on = 1'b1;
        next_r.current = CUR_PREQUAL_50;
      end
      PH_FULL, PH_CV, PH_TOPOFF: begin
        next_r.charge_on = 1'b1;
        // On the adapter the program resistor sets the rate; select only picks timers.
        if (have_adapter) begin
          next_r.current = CUR_PROGRAM;
        end else begin
          next_r.current = r.dgl_val[DGL_BUS_SEL] ? CUR_BUS_500 : CUR_BUS_100;
        end
      end
      default: next_r.current = CUR_OFF;
    endcase
    // Top-off is flagged apart from constant voltage, so the move into it shows at cv_mode; the status pins stay the same.
    next_r.cv_mode = next_r.phase == PH_CV;
    next_r.regulator_on = next_r.phase == PH_REGULATOR;

    // ****************************************
    // APB slave
    // ****************************************
    // One wait state: data is prepared in the first access cycle, the write lands
    // on the completing edge.
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = '0;
      case (paddr)
        ADDR_CONFIG: next_r.prdata = {30'h0, r.config_bits};
        ADDR_STATUS: next_r.prdata = {22'h0, r.stat_b_oe, r.stat_a_oe, r.source_adapter,
                                      r.dgl_val[DGL_INHIBIT], r.dgl_val[DGL_BUS_SEL],
                                      r.phase == PH_BAD, r.phase};
        ADDR_TIMER: next_r.prdata = {6'h0, r.timer};
        default: next_r.pslverr = 1'b1;
      endcase
    end
    // Writes to the read-only registers land nowhere and raise no error.
    if (psel && penable && r.pready && pwrite && pstrb[0] && paddr == ADDR_CONFIG) begin
      next_r.config_bits = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.phase <= PH_OFF;
      r.held <= PH_OFF;
      r.current <= CUR_OFF;
      r.config_bits <= CFG_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign status_out_a = r.stat_a;
  assign status_out_a_oe = r.stat_a_oe;
  assign status_out_b = r.stat_b;
  assign status_out_b_oe = r.stat_b_oe;
  assign charge_current = r.current;
  assign charge_on = r.charge_on;
  assign cv_mode = r.cv_mode;
  assign regulator_on = r.regulator_on;
  assign source_adapter = r.source_adapter;

endmodule

//--- shared/charge_seq_pkg.sv
// Constants, types and the state record of the charge cycle sequencer.
// Assumes a 125 MHz pclk; every slow time is counted in 1 ms ticks.
package charge_seq_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 8;
  localparam int TICK_NS = 1_000_000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W = 17;
  localparam int MIN_MS = 60_000;
  localparam int HOUR_MS = 60 * MIN_MS;
  localparam int PREQUAL_MIN = 30;
  localparam int CHG_STD_H = 5;
  localparam int CHG_LONG_H = 10;
  localparam int TOP_STD_MIN = 30;
  localparam int TOP_LONG_MIN = 60;
  localparam int DGL_PIN_MS = 40;
  localparam int DGL_EOC_MS = 300;
  localparam int TIMER_W = 26;
  localparam int DGL_W = 9;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TIMER = 8'h08;
  localparam int CFG_SEL_TIMER = 0;
  localparam int CFG_REGULATOR = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // ****************************************
  // Input bit positions
  // ****************************************
  localparam int IN_ADAPTER = 0;
  localparam int IN_BUS_PWR = 1;
  localparam int IN_ABOVE_FULL = 2;
  localparam int IN_AT_TERM = 3;
  localparam int IN_BELOW_RESTART = 4;
  localparam int IN_EOC = 5;
  localparam int IN_TOPOFF = 6;
  localparam int IN_TS_COLD = 7;
  localparam int IN_TS_HOT = 8;
  localparam int IN_TS_FLOAT = 9;
  localparam int IN_INHIBIT = 10;
  localparam int IN_BUS_SEL = 11;
  localparam int N_IN = 12;
  localparam int N_DGL = 4;
  localparam int DGL_INHIBIT = 0;
  localparam int DGL_BUS_SEL = 1;
  localparam int DGL_EOC = 2;
  localparam int DGL_TOPOFF = 3;
  localparam int DGL_SRC [N_DGL] = '{IN_INHIBIT, IN_BUS_SEL, IN_EOC, IN_TOPOFF};
  localparam int DGL_MS [N_DGL] = '{DGL_PIN_MS, DGL_PIN_MS, DGL_EOC_MS, DGL_EOC_MS};

  typedef enum logic [3:0] {
    PH_OFF, PH_PREQUAL, PH_FULL, PH_CV, PH_TOPOFF, PH_MAINT,
    PH_BAD, PH_SUSPEND, PH_INHIBIT, PH_REGULATOR
  } phase_t;

  typedef enum logic [2:0] {
    CUR_OFF, CUR_PREQUAL_50, CUR_PROGRAM, CUR_BUS_100, CUR_BUS_500
  } current_t;

  typedef struct packed {
    logic [N_IN-1:0] sync1;
    logic [N_IN-1:0] sync2;
    logic [N_IN-1:0] sync3;
    logic [N_IN-1:0] stable;
    logic [N_DGL-1:0] dgl_val;
    logic [N_DGL-1:0][DGL_W-1:0] dgl_cnt;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    phase_t phase;
    phase_t held;
    logic [TIMER_W-1:0] timer;
    logic [1:0] config_bits;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic stat_a_oe;
    logic stat_b_oe;
    logic stat_a;
    logic stat_b;
    current_t current;
    logic charge_on;
    logic cv_mode;
    logic regulator_on;
    logic source_adapter;
  } seq_state_t;

endpackage

//--- verification/seq_checker.sv
// Checker for the charge cycle sequencer: phase, status and filter timing.
// Assumes it is bound into charge_cycle_sequencer and gets its TICK_LEN.
`timescale 1ns/100ps
module seq_checker
  import charge_seq_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic adapter_input,
  input wire logic current_at_eoc,
  input wire logic ts_too_hot,
  input wire logic bus_select,
  input wire logic status_out_a,
  input wire logic status_out_b,
  input wire logic status_out_a_oe,
  input wire logic status_out_b_oe,
  input wire current_t charge_current,
  input wire logic charge_on,
  input wire logic cv_mode,
  input wire logic regulator_on,
  input wire logic source_adapter
);
  localparam int SEL_MIN = TICK_LEN * (DGL_PIN_MS - 1);
  localparam int SEL_MAX = TICK_LEN * (DGL_PIN_MS + 2) + 10;
  localparam int EOC_MIN = TICK_LEN * (DGL_EOC_MS - 1);
  logic [31:0] sel_cnt;
  logic [31:0] eoc_cnt;
  logic bad;
  assign bad = status_out_a_oe && status_out_b_oe && !regulator_on;
  // Raw pin ages; the filters inside lag these by the synchroniser depth.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_cnt <= '0;
      eoc_cnt <= '0;
    end else begin
      sel_cnt <= bus_select ? sel_cnt + 1'h1 : '0;
      eoc_cnt <= current_at_eoc ? eoc_cnt + 1'h1 : '0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence hot_held;
    ts_too_hot [*8];
  endsequence
  sequence sel_settled;
    (sel_cnt > SEL_MAX) ##0 charge_current inside {CUR_BUS_100, CUR_BUS_500};
  endsequence
  a_pad_low: assert property (!status_out_a && !status_out_b)
    else $error("status pad data not low");
  a_quiet_idle: assert property (!status_out_a_oe && !status_out_b_oe |-> !charge_on)
    else $error("charging with both status off");
  a_hot_suspend: assert property (hot_held ##0 !(status_out_a_oe && status_out_b_oe)
    |-> !status_out_a_oe && !status_out_b_oe && !charge_on) else $error("hot not suspended");
  a_reg_status: assert property (regulator_on |-> status_out_a_oe && status_out_b_oe
    && source_adapter) else $error("regulator status wrong");
  a_prequal_code: assert property (charge_current == CUR_PREQUAL_50
    |-> status_out_a_oe && !status_out_b_oe) else $error("prequal status wrong");
  a_cv_code: assert property (cv_mode |-> status_out_a_oe && !status_out_b_oe)
    else $error("cv status wrong");
  a_source_rate: assert property (charge_current inside {CUR_PROGRAM, CUR_BUS_100,
    CUR_BUS_500} |-> source_adapter == (charge_current == CUR_PROGRAM))
    else $error("rate does not match source");
  a_sel_rate: assert property (sel_settled |-> charge_current == CUR_BUS_500)
    else $error("bus select high not 500");
  a_sel_filter: assert property ($rose(charge_current == CUR_BUS_500) |-> sel_cnt >= SEL_MIN)
    else $error("bus select taken too early");
  a_eoc_filter: assert property ($fell(cv_mode) && charge_on |-> eoc_cnt >= EOC_MIN)
    else $error("end of charge taken too early");
  a_bad_stop: assert property (bad |-> !charge_on)
    else $error("charging with bad battery");
  a_bad_latched: assert property ((bad && adapter_input) [*8] |=> bad)
    else $error("bad battery cleared with power");
endmodule

bind charge_cycle_sequencer seq_checker #(.TICK_LEN(TICK_LEN)) i_seq_checker (
  .pclk, .presetn, .adapter_input, .current_at_eoc, .ts_too_hot, .bus_select,
  .status_out_a, .status_out_b, .status_out_a_oe, .status_out_b_oe, .charge_current,
  .charge_on, .cv_mode, .regulator_on, .source_adapter);

//--- verification/pack_model.sv
// Far side model: pack thermistor, host pause line and status pull-ups.
// Assumes the status pads are open drain with pull-up resistors.
`timescale 1ns/100ps
module pack_model (
  input wire logic [1:0] temp_code,
  input wire logic pause,
  input wire logic status_out_a,
  input wire logic status_out_a_oe,
  input wire logic status_out_b,
  input wire logic status_out_b_oe,
  output logic ts_too_cold,
  output logic ts_too_hot,
  output logic ts_floating,
  output logic charge_inhibit,
  output logic pin_a,
  output logic pin_b
);
  // Code 0 in range, 1 cold, 2 hot, 3 pack removed.
  assign ts_too_cold = temp_code == 2'h1;
  assign ts_too_hot = temp_code == 2'h2;
  // A removed pack raises only the open-input flag, so the device must decide itself.
  assign ts_floating = temp_code == 2'h3;
  assign charge_inhibit = pause;
  assign pin_a = status_out_a_oe ? status_out_a : 1'h1;
  assign pin_b = status_out_b_oe ? status_out_b : 1'h1;
endmodule

//--- verification/charge_cycle_sequencer_bench.sv
// Bench: drives supplies, battery comparators and APB, judges phases and pins.
// Assumes the pack model for thermistor, host pause and pull-ups.
`timescale 1ns/100ps
module charge_cycle_sequencer_bench
  import charge_seq_pkg::*;
;
  localparam int T = 4;
  // Ticks per minute in simulation, so the safety timers run out within the run.
  localparam int M = 12;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, t1;
  logic adapter_input = 0, bus_power_input = 0, above = 0, at_term = 0, below = 0;
  logic eoc = 0, topoff = 0, bus_select = 0, pause = 0, ts_too_cold, ts_too_hot;
  logic ts_floating, charge_inhibit, status_out_a, status_out_b, a_oe, b_oe, pin_a, pin_b;
  logic charge_on, cv_mode, regulator_on, source_adapter;
  logic [1:0] temp_code = '0;
  current_t charge_current;
  int n_errors = 0, num_checks = 0, cyc = 0;
  always #4 pclk = ~pclk;
  charge_cycle_sequencer #(.TICK_LEN(T), .MIN_TICKS(M)) i_charge_cycle_sequencer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .pready,
    .prdata, .pslverr, .adapter_input, .bus_power_input, .batt_above_full_rate(above),
    .batt_at_term(at_term), .batt_below_restart(below), .current_at_eoc(eoc),
    .current_at_topoff(topoff), .ts_too_cold, .ts_too_hot, .ts_floating, .charge_inhibit,
    .bus_select, .status_out_a, .status_out_a_oe(a_oe), .status_out_b,
    .status_out_b_oe(b_oe), .charge_current, .charge_on, .cv_mode, .regulator_on,
    .source_adapter);
  pack_model i_pack_model (.temp_code, .pause, .status_out_a, .status_out_a_oe(a_oe),
    .status_out_b, .status_out_b_oe(b_oe), .ts_too_cold, .ts_too_hot, .ts_floating,
    .charge_inhibit, .pin_a, .pin_b);
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Poll between edges, so pready is seen as it stands at the coming rising edge.
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    if (n >= 40) chk("pready", 1'h0, 1'h1);
  endtask
  task automatic st(input phase_t ph, input logic a, input logic b);
    apb(1'h0, ADDR_STATUS, '0);
    chk("phase", rd[3:0], ph);
    chk("pin_a", pin_a, !a);
    chk("pin_b", pin_b, !b);
  endtask
  task automatic t_regs;
    apb(1'h0, ADDR_CONFIG, '0);
    chk("config reset", rd, CFG_RESET);
    apb(1'h1, ADDR_CONFIG, 32'h0000_0003);
    apb(1'h0, ADDR_CONFIG, '0);
    chk("config rw", rd, 32'h0000_0003);
    apb(1'h1, ADDR_CONFIG, '0);
    apb(1'h0, 8'h0c, '0);
    chk("unmapped err", err, 1'h1);
    chk("unmapped data", rd, '0);
    apb(1'h1, ADDR_STATUS, 32'hffff_ffff);
    chk("ro err", err, 1'h0);
    st(PH_OFF, 1'h0, 1'h0);
    $display("test regs done");
  endtask
  task automatic t_cycle;
    adapter_input <= 1'h1;
    wt(10);
    st(PH_PREQUAL, 1'h1, 1'h0);
    chk("i prequal", charge_current, CUR_PREQUAL_50);
    wt(30 * T);
    temp_code <= 2'h2;
    wt(10);
    st(PH_SUSPEND, 1'h0, 1'h0);
    above <= 1'h1;
    wt(10);
    temp_code <= 2'h0;
    wt(10);
    st(PH_FULL, 1'h1, 1'h0);
    chk("i full", charge_current, CUR_PROGRAM);
    apb(1'h0, ADDR_TIMER, '0);
    chk("new timer", rd < 5, 1'h1);
    wt(30 * T);
    temp_code <= 2'h1;
    wt(10);
    apb(1'h0, ADDR_TIMER, '0);
    t1 = rd;
    wt(20 * T);
    apb(1'h0, ADDR_TIMER, '0);
    chk("held", rd, t1);
    temp_code <= 2'h0;
    wt(10 * T);
    apb(1'h0, ADDR_TIMER, '0);
    chk("resumed", rd > t1 && rd < t1 + 20, 1'h1);
    at_term <= 1'h1;
    wt(10);
    st(PH_CV, 1'h1, 1'h0);
    chk("cv", cv_mode, 1'h1);
    apb(1'h0, ADDR_TIMER, '0);
    chk("cv timer", rd > t1, 1'h1);
    eoc <= 1'h1;
    wt(290 * T);
    st(PH_CV, 1'h1, 1'h0);
    wt(20 * T);
    st(PH_TOPOFF, 1'h1, 1'h0);
    apb(1'h0, ADDR_TIMER, '0);
    chk("topoff timer", rd < 25, 1'h1);
    topoff <= 1'h1;
    wt(310 * T);
    st(PH_MAINT, 1'h0, 1'h1);
    {at_term, eoc, topoff} <= 3'h0;
    below <= 1'h1;
    wt(10);
    st(PH_FULL, 1'h1, 1'h0);
    apb(1'h0, ADDR_TIMER, '0);
    chk("restart timer", rd < 5, 1'h1);
    below <= 1'h0;
    $display("test charge cycle done");
  endtask
  task automatic t_pause;
    pause <= 1'h1;
    wt(30 * T);
    st(PH_FULL, 1'h1, 1'h0);
    wt(15 * T);
    st(PH_INHIBIT, 1'h0, 1'h0);
    chk("inhibit on", charge_on, 1'h0);
    pause <= 1'h0;
    wt(50 * T);
    st(PH_FULL, 1'h1, 1'h0);
    $display("test pause done");
  endtask
  task automatic t_float;
    temp_code <= 2'h3;
    wt(10);
    st(PH_SUSPEND, 1'h0, 1'h0);
    apb(1'h1, ADDR_CONFIG, 32'h0000_0002);
    wt(10);
    st(PH_REGULATOR, 1'h1, 1'h1);
    chk("reg on", regulator_on, 1'h1);
    adapter_input <= 1'h0;
    bus_power_input <= 1'h1;
    wt(10);
    chk("reg on bus", regulator_on, 1'h0);
    apb(1'h0, ADDR_STATUS, '0);
    chk("reg phase", rd[3:0] == PH_REGULATOR, 1'h0);
    $display("test float done");
  endtask
  task automatic t_bus;
    temp_code <= 2'h0;
    apb(1'h1, ADDR_CONFIG, '0);
    wt(20);
    st(PH_FULL, 1'h1, 1'h0);
    chk("bus src", source_adapter, 1'h0);
    chk("i bus low", charge_current, CUR_BUS_100);
    bus_select <= 1'h1;
    wt(30 * T);
    chk("i unfiltered", charge_current, CUR_BUS_100);
    wt(15 * T);
    chk("i bus high", charge_current, CUR_BUS_500);
    adapter_input <= 1'h1;
    wt(10);
    chk("both src", source_adapter, 1'h1);
    chk("i both", charge_current, CUR_PROGRAM);
    $display("test bus done");
  endtask
  task automatic t_bad;
    {adapter_input, bus_power_input, above, bus_select} <= 4'h0;
    wt(10);
    st(PH_OFF, 1'h0, 1'h0);
    adapter_input <= 1'h1;
    wt((PREQUAL_MIN * M - 8) * T);
    st(PH_PREQUAL, 1'h1, 1'h0);
    wt(16 * T);
    st(PH_BAD, 1'h1, 1'h1);
    chk("bad stop", charge_on, 1'h0);
    {above, bus_power_input, adapter_input} <= 3'h6;
    wt(10);
    st(PH_BAD, 1'h1, 1'h1);
    bus_power_input <= 1'h0;
    wt(10);
    st(PH_OFF, 1'h0, 1'h0);
    adapter_input <= 1'h1;
    wt((CHG_STD_H * (HOUR_MS / MIN_MS) * M - 8) * T);
    st(PH_FULL, 1'h1, 1'h0);
    wt(16 * T);
    st(PH_BAD, 1'h1, 1'h1);
    chk("bad timer", charge_on, 1'h0);
    $display("test bad battery done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    wt(5);
    presetn <= 1'h1;
    wt(1);
    t_regs;
    t_cycle;
    t_pause;
    t_float;
    t_bus;
    t_bad;
    conclude;
  end
  // The whole run needs about 20000 cycles; the ceiling leaves ample margin.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      conclude;
    end
  end
endmodule
